// ===== logic/emcr_defines.svh
// Purpose: Offsets, field positions and reset values of the meter bank.
// Assumes: Included by the bank and the testbench, never compiled alone.
// Notes: Internal indices are the values of the internal address pointer.
`ifndef EMCR_DEFINES_SVH
`define EMCR_DEFINES_SVH

// ==========================================================================
// APB window
`define EMCR_APB_PTR 8'h00
`define EMCR_APB_DATA 8'h04
`define EMCR_APB_STAT 8'h08

// ==========================================================================
// Internal register indices
`define EMCR_IDX_MEASURE_MODE_ONE 7'h0b
`define EMCR_IDX_MEASURE_MODE_TWO 7'h0c
`define EMCR_IDX_REACTIVE_ENERGY_DIVIDER 7'h25
`define EMCR_IDX_APPARENT_ENERGY_DIVIDER 7'h26
`define EMCR_IDX_ANUM 7'h27
`define EMCR_IDX_ADEN 7'h28
`define EMCR_IDX_BNUM 7'h29
`define EMCR_IDX_BDEN 7'h2a
`define EMCR_IDX_RSV3B 7'h3b
`define EMCR_IDX_RSV3C 7'h3c
`define EMCR_IDX_CAL 7'h3d
`define EMCR_IDX_RSV3E 7'h3e
`define EMCR_IDX_RSV3F 7'h3f

// ==========================================================================
// Mode register fields
`define EMCR_M1_SOFT_RESET 7
`define EMCR_M1_ZX_BYPASS 6
`define EMCR_M1_INTEGRATOR 5
`define EMCR_M1_EXCHANGE 4
`define EMCR_M1_SLEEP 3
`define EMCR_M1_B_OFF 2
`define EMCR_M1_A_OFF 1
`define EMCR_M1_HPF_BYPASS 0
`define EMCR_M2_B_SRC_HI 7
`define EMCR_M2_B_SRC_LO 6
`define EMCR_M2_A_SRC_HI 5
`define EMCR_M2_A_SRC_LO 4
`define EMCR_M2_RMS_SEL 3
`define EMCR_M2_RMS_ZX 2

// ==========================================================================
// Reset values and pulse scaling
`define EMCR_RST_MEASURE_MODE_ONE 8'h06
`define EMCR_RST_MEASURE_MODE_TWO 8'h40
`define EMCR_RST_DEN 16'h003f
`define EMCR_RST_RSV3C 16'h0300
`define EMCR_PULSE_SHIFT 16

`endif

// ===== logic/emcr_pkg.sv
// Purpose: Types shared by the meter configuration bank.
// Assumes: Constants live in emcr_defines.svh.
// Notes: None.
package emcr_pkg;

  // ==========================================================================
  // Pulse source codes and bus answer states
  typedef enum logic [1:0] {
    EMCR_SRC_ACTIVE = 2'b00,
    EMCR_SRC_REACTIVE = 2'b01,
    EMCR_SRC_APP_LO = 2'b10,
    EMCR_SRC_APP_HI = 2'b11
  } emcr_src_t;

  typedef enum logic {
    EMCR_APB_IDLE = 1'b0,
    EMCR_APB_ANSWER = 1'b1
  } emcr_apb_state_t;

endpackage

// ===== logic/emcr_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for a pin.
// Assumes: One clock, synchronous active-low reset.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/10ps
module emcr_sync (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic pinIn,
  output logic level
);
  logic stage1_q;
  logic stage2_q;
  logic stage3_q;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      stage1_q <= 1'b0;
      stage2_q <= 1'b0;
      stage3_q <= 1'b0;
    end else begin
      stage1_q <= pinIn;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
    end
  end

  // The level only moves once the last two stages agree.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      level <= 1'b0;
    end else if (stage2_q == stage3_q) begin
      level <= stage3_q;
    end
  end
endmodule

// ===== logic/emcr_pulse_gen.sv
// Purpose: Rate scaler making one pulse output from a source magnitude.
// Assumes: Source is an unsigned magnitude on the same clock.
// Notes: At most one pulse per cycle; a zero denominator stops output.
`timescale 1ns/10ps
module emcr_pulse_gen (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic enable,
  input wire logic [15:0] source,
  input wire logic [15:0] numerator,
  input wire logic [15:0] denominator,
  output logic pulse
);
  logic [32:0] acc_q;
  logic [32:0] acc_d;
  logic [32:0] threshold;
  logic fire;

  // Rate per cycle is source times numerator over denominator shifted left by 16.
  always_comb begin
    threshold = {1'b0, denominator, 16'h0000};
    acc_d = acc_q + {1'b0, 32'(source) * 32'(numerator)};
    fire = (denominator != 16'h0000) && (acc_d >= threshold);
    if (fire) begin
      acc_d = acc_d - threshold;
      if (acc_d >= threshold) begin
        acc_d = threshold - 33'h0_0000_0001;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn || !enable) begin
      acc_q <= 33'h0_0000_0000;
      pulse <= 1'b0;
    end else begin
      acc_q <= acc_d;
      pulse <= fire;
    end
  end
endmodule

// ===== logic/emcr_config_regs.sv
// Purpose: Configuration bank of the meter engine, reached over APB.
// Assumes: Datapath magnitudes and the rms ready strobe share sys_clk.
// Notes: Internal registers are reached through the address pointer.
`timescale 1ns/10ps
`include "emcr_defines.svh"
module emcr_config_regs
  import emcr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] activePower,
  input wire logic [15:0] reactivePower,
  input wire logic [15:0] apparentPower,
  input wire logic [15:0] currentRms,
  input wire logic rmsReady,
  input wire logic voltZeroCross,
  output logic zeroCrossFilterBypass,
  output logic integratorOn,
  output logic channelExchange,
  output logic converterSleep,
  output logic highpassBypass,
  output logic apparentAccumRms,
  output logic rmsUpdate,
  output logic [7:0] reactiveDivider,
  output logic [7:0] apparentDivider,
  output logic [7:0] calibrationMode,
  output logic pulseOutA,
  output logic pulseOutB
);

  // ==========================================================================
  // Storage
  logic [6:0] addrPtr_q;
  logic [7:0] measure_mode_one_q;
  logic [7:0] measure_mode_two_q;
  logic [15:0] numA_q;
  logic [15:0] denA_q;
  logic [15:0] numB_q;
  logic [15:0] denB_q;
  logic [7:0] rsv3b_q;
  logic [15:0] rsv3c_q;
  logic [7:0] rsv3e_q;
  logic [7:0] rsv3f_q;
  emcr_apb_state_t apbState_q;
  logic zxLevel;
  logic zxLevelPrev_q;
  logic zxRise;
  logic apbWrite;
  logic wrPtr;
  logic wrData;
  logic softReset;
  logic ptrMapped;
  logic apbMapped;
  logic [15:0] intRead;
  logic [31:0] apbRead;
  emcr_src_t srcSelA;
  emcr_src_t srcSelB;
  logic [15:0] srcA;
  logic [15:0] srcB;

  // ==========================================================================
  // Pin synchroniser for the voltage zero crossing
  emcr_sync u_zxSync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .pinIn(voltZeroCross),
    .level(zxLevel)
  );

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      zxLevelPrev_q <= 1'b0;
    end else begin
      zxLevelPrev_q <= zxLevel;
    end
  end

  assign zxRise = zxLevel && !zxLevelPrev_q;

  // ==========================================================================
  // APB decode
  always_comb begin
    apbMapped = (paddr == `EMCR_APB_PTR) || (paddr == `EMCR_APB_DATA) ||
      (paddr == `EMCR_APB_STAT);
    apbWrite = (apbState_q == EMCR_APB_ANSWER) && psel && penable &&
      pwrite && !pslverr;
    wrPtr = apbWrite && (paddr == `EMCR_APB_PTR);
    wrData = apbWrite && (paddr == `EMCR_APB_DATA);
  end

  assign softReset = wrData && (addrPtr_q == `EMCR_IDX_MEASURE_MODE_ONE) &&
    pwdata[`EMCR_M1_SOFT_RESET];

  // ==========================================================================
  // Internal read selection
  // pointer selects register
  always_comb begin
    ptrMapped = 1'b1;
    intRead = 16'h0000;
    unique case (addrPtr_q)
      `EMCR_IDX_MEASURE_MODE_ONE: intRead = {8'h00, measure_mode_one_q};
      `EMCR_IDX_MEASURE_MODE_TWO: intRead = {8'h00, measure_mode_two_q};
      `EMCR_IDX_REACTIVE_ENERGY_DIVIDER: intRead = {8'h00, reactiveDivider};
      `EMCR_IDX_APPARENT_ENERGY_DIVIDER: intRead = {8'h00, apparentDivider};
      `EMCR_IDX_ANUM: intRead = numA_q;
      `EMCR_IDX_ADEN: intRead = denA_q;
      `EMCR_IDX_BNUM: intRead = numB_q;
      `EMCR_IDX_BDEN: intRead = denB_q;
      `EMCR_IDX_RSV3B: intRead = {8'h00, rsv3b_q};
      `EMCR_IDX_RSV3C: intRead = rsv3c_q;
      `EMCR_IDX_CAL: intRead = {8'h00, calibrationMode};
      `EMCR_IDX_RSV3E: intRead = {8'h00, rsv3e_q};
      `EMCR_IDX_RSV3F: intRead = {8'h00, rsv3f_q};
      default: ptrMapped = 1'b0;
    endcase
  end

  always_comb begin
    apbRead = 32'h0000_0000;
    if (paddr == `EMCR_APB_PTR) begin
      apbRead = {25'h000_0000, addrPtr_q};
    end else if (paddr == `EMCR_APB_DATA) begin
      apbRead = {16'h0000, intRead};
    end else if (paddr == `EMCR_APB_STAT) begin
      apbRead = {28'h000_0000, pulseOutB, pulseOutA, zxLevel, ptrMapped};
    end
  end

  // ==========================================================================
  // APB answer: ready one cycle after the setup edge
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      apbState_q <= EMCR_APB_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      unique case (apbState_q)
        EMCR_APB_IDLE: begin
          if (psel && !penable) begin
            apbState_q <= EMCR_APB_ANSWER;
            pready <= 1'b1;
            pslverr <= !apbMapped;
            prdata <= (apbMapped && !pwrite) ? apbRead : 32'h0000_0000;
          end
        end
        EMCR_APB_ANSWER: begin
          apbState_q <= EMCR_APB_IDLE;
          pready <= 1'b0;
          pslverr <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================================
  // Address pointer
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      addrPtr_q <= 7'h00;
    end else if (wrPtr) begin
      addrPtr_q <= pwdata[6:0];
    end
  end

  // ==========================================================================
  // Mode registers; the soft reset bit never stays set
  always_ff @(posedge sys_clk) begin
    if (!resetn || softReset) begin
      measure_mode_one_q <= `EMCR_RST_MEASURE_MODE_ONE;
      measure_mode_two_q <= `EMCR_RST_MEASURE_MODE_TWO;
    end else if (wrData) begin
      if (addrPtr_q == `EMCR_IDX_MEASURE_MODE_ONE) begin
        measure_mode_one_q <= {1'b0, pwdata[6:0]};
      end
      if (addrPtr_q == `EMCR_IDX_MEASURE_MODE_TWO) begin
        measure_mode_two_q <= pwdata[7:0];
      end
    end
  end

  // ==========================================================================
  // Scaling registers
  always_ff @(posedge sys_clk) begin
    if (!resetn || softReset) begin
      reactiveDivider <= 8'h00;
      apparentDivider <= 8'h00;
      numA_q <= 16'h0000;
      numB_q <= 16'h0000;
      denA_q <= `EMCR_RST_DEN;
      denB_q <= `EMCR_RST_DEN;
    end else if (wrData) begin
      unique case (addrPtr_q)
        `EMCR_IDX_REACTIVE_ENERGY_DIVIDER: reactiveDivider <= pwdata[7:0];
        `EMCR_IDX_APPARENT_ENERGY_DIVIDER: apparentDivider <= pwdata[7:0];
        `EMCR_IDX_ANUM: numA_q <= pwdata[15:0];
        `EMCR_IDX_ADEN: denA_q <= pwdata[15:0];
        `EMCR_IDX_BNUM: numB_q <= pwdata[15:0];
        `EMCR_IDX_BDEN: denB_q <= pwdata[15:0];
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // Reserved and calibration registers
  // reserved registers keep written values
  always_ff @(posedge sys_clk) begin
    if (!resetn || softReset) begin
      rsv3b_q <= 8'h00;
      rsv3c_q <= `EMCR_RST_RSV3C;
      rsv3e_q <= 8'h00;
      rsv3f_q <= 8'h00;
      calibrationMode <= 8'h00;
    end else if (wrData) begin
      unique case (addrPtr_q)
        `EMCR_IDX_RSV3B: rsv3b_q <= pwdata[7:0];
        `EMCR_IDX_RSV3C: rsv3c_q <= pwdata[15:0];
        `EMCR_IDX_RSV3E: rsv3e_q <= pwdata[7:0];
        `EMCR_IDX_RSV3F: rsv3f_q <= pwdata[7:0];
        `EMCR_IDX_CAL: calibrationMode <= pwdata[7:0];
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // Datapath controls, registered from the mode bits
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      zeroCrossFilterBypass <= 1'b0;
      integratorOn <= 1'b0;
      channelExchange <= 1'b0;
      converterSleep <= 1'b0;
      highpassBypass <= 1'b0;
      apparentAccumRms <= 1'b0;
    end else begin
      zeroCrossFilterBypass <= measure_mode_one_q[`EMCR_M1_ZX_BYPASS];
      integratorOn <= measure_mode_one_q[`EMCR_M1_INTEGRATOR];
      channelExchange <= measure_mode_one_q[`EMCR_M1_EXCHANGE];
      converterSleep <= measure_mode_one_q[`EMCR_M1_SLEEP];
      highpassBypass <= measure_mode_one_q[`EMCR_M1_HPF_BYPASS];
      apparentAccumRms <= measure_mode_two_q[`EMCR_M2_RMS_SEL];
    end
  end

  // ==========================================================================
  // Rms update timing
  // update on a rising zero crossing when EMCR_M2_RMS_ZX is set, else on rmsReady
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rmsUpdate <= 1'b0;
    end else if (measure_mode_two_q[`EMCR_M2_RMS_ZX]) begin
      rmsUpdate <= zxRise;
    end else begin
      rmsUpdate <= rmsReady;
    end
  end

  // ==========================================================================
  // Pulse output sources
  assign srcSelA = emcr_src_t'(measure_mode_two_q[`EMCR_M2_A_SRC_HI:`EMCR_M2_A_SRC_LO]);
  assign srcSelB = emcr_src_t'(measure_mode_two_q[`EMCR_M2_B_SRC_HI:`EMCR_M2_B_SRC_LO]);

  // mixed apparent and rms relies on software
  always_comb begin
    unique case (srcSelA)
      EMCR_SRC_ACTIVE: srcA = activePower;
      EMCR_SRC_REACTIVE: srcA = reactivePower;
      EMCR_SRC_APP_LO, EMCR_SRC_APP_HI:
        srcA = measure_mode_two_q[`EMCR_M2_RMS_SEL] ? currentRms : apparentPower;
    endcase
    unique case (srcSelB)
      EMCR_SRC_ACTIVE: srcB = activePower;
      EMCR_SRC_REACTIVE: srcB = reactivePower;
      EMCR_SRC_APP_LO, EMCR_SRC_APP_HI:
        srcB = measure_mode_two_q[`EMCR_M2_RMS_SEL] ? currentRms : apparentPower;
    endcase
  end

  emcr_pulse_gen u_pulseA (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .enable(!measure_mode_one_q[`EMCR_M1_A_OFF]),
    .source(srcA),
    .numerator(numA_q),
    .denominator(denA_q),
    .pulse(pulseOutA)
  );

  emcr_pulse_gen u_pulseB (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .enable(!measure_mode_one_q[`EMCR_M1_B_OFF]),
    .source(srcB),
    .numerator(numB_q),
    .denominator(denB_q),
    .pulse(pulseOutB)
  );

  // ==========================================================================
  // Checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  chk_soft_reset_all: assert property (
    softReset |=> measure_mode_one_q == `EMCR_RST_MEASURE_MODE_ONE && denA_q == `EMCR_RST_DEN &&
      numB_q == 16'h0000 && rsv3c_q == `EMCR_RST_RSV3C)
    else $error("soft reset did not restore defaults");

  chk_zx_bypass_follow: assert property (
    wrData && addrPtr_q == `EMCR_IDX_MEASURE_MODE_ONE && !pwdata[7]
      |=> ##1 zeroCrossFilterBypass == $past(pwdata[6], 2))
    else $error("zero-cross bypass did not follow mode one");

  chk_integrator_follow: assert property (
    ##1 integratorOn == $past(measure_mode_one_q[`EMCR_M1_INTEGRATOR]))
    else $error("integrator control lags mode one");

  chk_output_b_off: assert property (
    measure_mode_one_q[`EMCR_M1_B_OFF] |=> !pulseOutB)
    else $error("pulse output B fired while disabled");

  chk_output_a_off: assert property (
    measure_mode_one_q[`EMCR_M1_A_OFF] |=> !pulseOutA)
    else $error("pulse output A fired while disabled");

  chk_src_b_select: assert property (
    srcSelB[1] && measure_mode_two_q[`EMCR_M2_RMS_SEL] |-> srcB == currentRms)
    else $error("output B source not current rms");

  chk_rms_on_cross: assert property (
    measure_mode_two_q[`EMCR_M2_RMS_ZX] && !rmsUpdate ##1 !zxRise |=> !rmsUpdate)
    else $error("rms update without zero crossing");

  chk_pointer_unmapped: assert property (
    psel && !penable && !pwrite && paddr == `EMCR_APB_DATA && !ptrMapped
      && apbState_q == EMCR_APB_IDLE |=> pready && prdata == 32'h0000_0000)
    else $error("unmapped pointer read not zero");

  chk_apb_ready_once: assert property (
    pready |=> !pready)
    else $error("ready stood longer than one cycle");

  cov_soft_reset: cover property (softReset);
  cov_pulse_a: cover property ($rose(pulseOutA));
  cov_rms_cross: cover property (measure_mode_two_q[`EMCR_M2_RMS_ZX] && rmsUpdate);
  cov_bad_address: cover property (pready && pslverr);

endmodule

// ===== tb/testbench.sv
// Purpose: Self-checking bench for the meter configuration bank.
// Assumes: Zero-wait APB slave, pointer at 0x00 and data window at 0x04.
// Notes: Pulse rates are judged by counts within a small tolerance band.
`timescale 1ns/10ps
`include "emcr_defines.svh"
module testbench
  import emcr_pkg::*;
;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [15:0] activePower = 16'h0000;
  logic [15:0] reactivePower = 16'h0000;
  logic [15:0] apparentPower = 16'h0000;
  logic [15:0] currentRms = 16'h0000;
  logic rmsReady = 1'b0;
  logic voltZeroCross = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, zeroCrossFilterBypass, integratorOn;
  logic channelExchange, converterSleep, highpassBypass;
  logic apparentAccumRms, rmsUpdate, pulseOutA, pulseOutB;
  logic [7:0] reactiveDivider, apparentDivider, calibrationMode;
  int errors = 0;
  int cmpCount = 0;
  logic [31:0] rdv;
  logic errv;
  int na, nb;
  logic [6:0] idxTab [13] = '{`EMCR_IDX_MEASURE_MODE_ONE, `EMCR_IDX_MEASURE_MODE_TWO,
    `EMCR_IDX_REACTIVE_ENERGY_DIVIDER, `EMCR_IDX_APPARENT_ENERGY_DIVIDER, `EMCR_IDX_ANUM, `EMCR_IDX_ADEN,
    `EMCR_IDX_BNUM, `EMCR_IDX_BDEN, `EMCR_IDX_RSV3B, `EMCR_IDX_RSV3C,
    `EMCR_IDX_CAL, `EMCR_IDX_RSV3E, `EMCR_IDX_RSV3F};
  logic [15:0] rstTab [13] = '{16'h0006, 16'h0040, 16'h0000, 16'h0000,
    16'h0000, 16'h003f, 16'h0000, 16'h003f, 16'h0000, 16'h0300,
    16'h0000, 16'h0000, 16'h0000};

  emcr_config_regs i_dut (.sys_clk(sys_clk), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .activePower(activePower), .reactivePower(reactivePower),
    .apparentPower(apparentPower), .currentRms(currentRms),
    .rmsReady(rmsReady), .voltZeroCross(voltZeroCross),
    .zeroCrossFilterBypass(zeroCrossFilterBypass),
    .integratorOn(integratorOn), .channelExchange(channelExchange),
    .converterSleep(converterSleep), .highpassBypass(highpassBypass),
    .apparentAccumRms(apparentAccumRms), .rmsUpdate(rmsUpdate),
    .reactiveDivider(reactiveDivider), .apparentDivider(apparentDivider),
    .calibrationMode(calibrationMode), .pulseOutA(pulseOutA),
    .pulseOutB(pulseOutB));

  // ==========================================================================
  // Shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmpCount++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmpCount, errors);
    if (errors == 0 && cmpCount > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // The request is held until pready is sampled high at a rising edge.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      errors++;
      $display("No bus answer before the time limit");
      close_out();
    end
  endtask

  task automatic wr_reg(input logic [6:0] idx, input logic [31:0] v);
    apb(1'b1, `EMCR_APB_PTR, {25'h0, idx}, rdv, errv);
    apb(1'b1, `EMCR_APB_DATA, v, rdv, errv);
  endtask

  task automatic rd_reg(input logic [6:0] idx, output logic [31:0] v);
    apb(1'b1, `EMCR_APB_PTR, {25'h0, idx}, rdv, errv);
    apb(1'b0, `EMCR_APB_DATA, 32'h0000_0000, v, errv);
  endtask

  task automatic count_out(input int cyc, output int a, output int b);
    a = 0;
    b = 0;
    repeat (cyc) begin
      @(posedge sys_clk);
      a += (pulseOutA === 1'b1);
      b += (pulseOutB === 1'b1);
    end
  endtask

  // ==========================================================================
  // Scenarios
  task automatic test_reset();
    for (int i = 0; i < 13; i++) begin
      rd_reg(idxTab[i], rdv);
      check(rdv, {16'h0000, rstTab[i]});
    end
    $display("test reset values done");
  endtask

  task automatic test_rw();
    logic [31:0] exp;
    for (int i = 2; i < 11; i++) begin
      if (i < 8 || i == 10) begin
        exp = (i < 4 || i == 10) ? 32'h0000_00c3 : 32'h0000_a5c3;
        wr_reg(idxTab[i], 32'hffff_a5c3);
        rd_reg(idxTab[i], rdv);
        check(rdv, exp);
      end
    end
    check({reactiveDivider, apparentDivider}, 16'hc3c3);
    $display("test read write done");
  endtask

  task automatic test_soft_reset();
    wr_reg(`EMCR_IDX_MEASURE_MODE_TWO, 32'h0000_0000);
    wr_reg(`EMCR_IDX_MEASURE_MODE_ONE, 32'h0000_0080);
    apb(1'b0, `EMCR_APB_DATA, 32'h0000_0000, rdv, errv);
    check(rdv, 32'h0000_0006);
    for (int i = 1; i < 13; i++) begin
      rd_reg(idxTab[i], rdv);
      check(rdv, {16'h0000, rstTab[i]});
    end
    $display("test soft reset done");
  endtask

  task automatic test_modes();
    int bitTab [5] = '{6, 5, 4, 3, 0};
    logic [7:0] m;
    for (int i = 0; i < 5; i++) begin
      m = 8'(1 << bitTab[i]);
      wr_reg(`EMCR_IDX_MEASURE_MODE_ONE, {24'h0, m});
      repeat (2) @(posedge sys_clk);
      check({zeroCrossFilterBypass, integratorOn, channelExchange,
             converterSleep, highpassBypass},
            {m[6], m[5], m[4], m[3], m[0]});
    end
    wr_reg(`EMCR_IDX_MEASURE_MODE_TWO, 32'h0000_0048);
    repeat (2) @(posedge sys_clk);
    check(apparentAccumRms, 1'b1);
    wr_reg(`EMCR_IDX_MEASURE_MODE_TWO, 32'h0000_0040);
    repeat (2) @(posedge sys_clk);
    check(apparentAccumRms, 1'b0);
    $display("test mode bits done");
  endtask

  task automatic test_rms();
    @(posedge sys_clk);
    rmsReady <= 1'b1;
    @(posedge sys_clk);
    rmsReady <= 1'b0;
    count_out(0, na, nb);
    na = 0;
    repeat (10) begin
      @(posedge sys_clk);
      na += (rmsUpdate === 1'b1);
    end
    check(na, 1);
    for (int z = 0; z < 2; z++) begin
      wr_reg(`EMCR_IDX_MEASURE_MODE_TWO, z ? 32'h0000_0044 : 32'h0000_0040);
      voltZeroCross <= 1'b1;
      na = 0;
      repeat (12) begin
        @(posedge sys_clk);
        na += (rmsUpdate === 1'b1);
      end
      check(na, z);
      voltZeroCross <= 1'b0;
      repeat (8) @(posedge sys_clk);
    end
    $display("test rms timing done");
  endtask

  task automatic test_pulse();
    logic [1:0] c;
    wr_reg(`EMCR_IDX_ANUM, 32'h0000_0001);
    wr_reg(`EMCR_IDX_ADEN, 32'h0000_0001);
    wr_reg(`EMCR_IDX_BNUM, 32'h0000_0001);
    wr_reg(`EMCR_IDX_BDEN, 32'h0000_0002);
    wr_reg(`EMCR_IDX_MEASURE_MODE_ONE, 32'h0000_0006);
    activePower <= 16'h8000;
    reactivePower <= 16'h8000;
    count_out(200, na, nb);
    check({na[15:0], nb[15:0]}, 32'h0000_0000);
    // output A steps through all four source codes, code 3 with current rms, while B is off.
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      activePower <= (i == 0) ? 16'h8000 : 16'h0000;
      reactivePower <= (i == 1) ? 16'h8000 : 16'h0000;
      apparentPower <= (i == 2) ? 16'h8000 : 16'h0000;
      currentRms <= (i == 3) ? 16'h8000 : 16'h0000;
      wr_reg(`EMCR_IDX_MEASURE_MODE_TWO, {24'h0, 2'b01, c, c == 2'b11, 3'b000});
      wr_reg(`EMCR_IDX_MEASURE_MODE_ONE, 32'h0000_0004);
      count_out(200, na, nb);
      check(na >= 95 && na <= 105, 1'b1);
      check(nb, 0);
    end
    apparentPower <= 16'h8000;
    wr_reg(`EMCR_IDX_MEASURE_MODE_TWO, 32'h0000_00c8);
    wr_reg(`EMCR_IDX_MEASURE_MODE_ONE, 32'h0000_0002);
    count_out(200, na, nb);
    check(nb >= 45 && nb <= 55, 1'b1);
    check(na, 0);
    $display("test pulse outputs done");
  endtask

  task automatic test_bus();
    apb(1'b0, 8'h10, 32'h0000_0000, rdv, errv);
    check({errv, rdv}, {1'b1, 32'h0000_0000});
    apb(1'b1, 8'h0c, 32'h0000_0000, rdv, errv);
    check(errv, 1'b1);
    apb(1'b1, `EMCR_APB_PTR, 32'h0000_0030, rdv, errv);
    apb(1'b1, `EMCR_APB_DATA, 32'h0000_1234, rdv, errv);
    apb(1'b0, `EMCR_APB_DATA, 32'h0000_0000, rdv, errv);
    check({errv, rdv}, {1'b0, 32'h0000_0000});
    apb(1'b0, `EMCR_APB_STAT, 32'h0000_0000, rdv, errv);
    check(rdv[0], 1'b0);
    apb(1'b1, `EMCR_APB_PTR, 32'h0000_00a7, rdv, errv);
    apb(1'b0, `EMCR_APB_PTR, 32'h0000_0000, rdv, errv);
    check(rdv, 32'h0000_0027);
    apb(1'b0, `EMCR_APB_DATA, 32'h0000_0000, rdv, errv);
    check(rdv, 32'h0000_0001);
    apb(1'b0, `EMCR_APB_STAT, 32'h0000_0000, rdv, errv);
    check(rdv[0], 1'b1);
    $display("test bus decoding done");
  endtask

  // ==========================================================================
  // Clock and main sequence
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    test_reset();
    test_rw();
    test_soft_reset();
    test_modes();
    test_rms();
    test_pulse();
    test_bus();
    close_out();
  end
endmodule
